// ---- include/fsl_map.vh ----
// flash security lockout: offsets, fields, reset values and timing counts
`ifndef FSL_MAP_VH
`define FSL_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FSL_OFF_STATUS    12'h000
`define FSL_OFF_CONTROL   12'h004
`define FSL_OFF_CLKDIV    12'h008
`define FSL_OFF_RECOVERY  12'h00c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FSL_ST_SECURED    0
`define FSL_ST_MODE_LO    1
`define FSL_ST_MODE_HI    2
`define FSL_ST_KEY_EN     3
`define FSL_ST_BACKDOOR   4
`define FSL_ST_STRAP      5
`define FSL_ST_ERASE_BUSY 6
`define FSL_ST_ERASED     7
`define FSL_CTL_UNLOCK    0
`define FSL_DIV_PRESCALE  6
`define FSL_RC_LOADED     7

// ----------------------------------------------------------------
// security byte decode: erased flash (all ones) is unsecured
// ----------------------------------------------------------------
`define FSL_SEC_LOCK_CODE 2'h2
`define FSL_KEY_EN_CODE   2'h2
`define FSL_ERASED_WORD   16'hffff

// ----------------------------------------------------------------
// boot modes, vectors and reset values
// ----------------------------------------------------------------
`define FSL_MODE_INTERNAL 2'h0
`define FSL_MODE_EXTERNAL 2'h1
`define FSL_MODE_SECURE   2'h2
`define FSL_BOOT_VECTOR   24'h020000
`define FSL_EXT_VECTOR    24'h000000
`define FSL_CLKDIV_RESET  7'h00

// ----------------------------------------------------------------
// tap instructions and id
// ----------------------------------------------------------------
`define FSL_IR_WIDTH      4
`define FSL_IR_IDCODE     4'h2
`define FSL_IR_LOCKOUT    4'h8
`define FSL_IR_BYPASS     4'hf
`define FSL_IR_CAPTURE    4'h1
`define FSL_IDCODE_VALUE  32'h12345671

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define FSL_ERASE_TICKS   16'd2000

`endif

// ---- verilog/fsl_lockout.v ----
// flash security lockout: boot mode, debug block and jtag recovery erase
//
// Behaviour
// - security comes from two non-volatile bytes held in the flash array.
// - secured part blocks every external program-space access.
// - at boot pick internal boot, external boot or secure mode.
// - secured part boots internally, fetching from the fixed boot flash address.
// - secured part ignores the external boot strap at reset.
// - debug-port memory reads disabled at reset from stored security bytes.
// - chip tap stays active after boot, secured or not, with id access.
// - lockout recovery mass-erases all flash, removing security.
// - unlock-erase instruction selects a 7-bit divider data register.
// - during recovery the jtag divider overrides the flash divider register.
// - divider bit 6 is prescale-by-eight select, bits 5..0 the ratio.
// - event clock is core clock halved, optional divide by 8, then ratio plus one.
// - erase starts in run-test/idle after update; host stays there until done.
// - backdoor unsecuring allowed only when the stored key enable bit is set.
// - reset asserts asynchronously but releases only on a rising clock edge.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`default_nettype none
`include "fsl_map.vh"
module fsl_lockout #(
  parameter        AW          = 12,               // apb address width
  parameter [15:0] ERASE_TICKS = `FSL_ERASE_TICKS  // event ticks per mass erase
) (
  input  wire          pclk,                   // core clock, 100 mhz
  input  wire          presetn,                // async reset, active low
  input  wire          psel,                   // apb select
  input  wire          penable,                // apb access phase
  input  wire          pwrite,                 // apb direction
  input  wire [AW-1:0] paddr,                  // apb byte address
  input  wire [31:0]   pwdata,                 // apb write data
  output reg  [31:0]   prdata,                 // apb read data
  output reg           pready,                 // apb ready
  output reg           pslverr,                // apb error, unmapped address
  input  wire [15:0]   nv_security_word,       // stored security bytes
  input  wire          external_boot_strap,    // boot strap pin
  input  wire          tck,                    // jtag test clock pin
  input  wire          tms,                    // jtag mode select pin
  input  wire          tdi,                    // jtag data in pin
  input  wire          trst_n,                 // jtag test reset pin
  output reg           tdo,                    // jtag data out
  output reg           tdo_oe,                 // jtag data out enable
  output reg           core_reset_n,           // clock-aligned internal reset
  output reg  [1:0]    boot_mode,              // latched functional mode
  output reg  [23:0]   boot_vector,            // first fetch address
  output reg           ext_pspace_block,       // external program space blocked
  output reg           debug_read_disable,     // debug_port memory reads off
  output reg           mass_erase_req,         // flash array mass erase active
  output reg           flash_event_tick        // timed-event clock enable
);
  // ----------------------------------------------------------------
  // tap states
  // ----------------------------------------------------------------
  localparam [3:0] T_RESET = 4'h0, T_IDLE = 4'h1, T_SEL_DR = 4'h2, T_CAP_DR = 4'h3;
  localparam [3:0] T_SH_DR = 4'h4, T_EX1_DR = 4'h5, T_PAU_DR = 4'h6, T_EX2_DR = 4'h7;
  localparam [3:0] T_UPD_DR = 4'h8, T_SEL_IR = 4'h9, T_CAP_IR = 4'ha, T_SH_IR = 4'hb;
  localparam [3:0] T_EX1_IR = 4'hc, T_PAU_IR = 4'hd, T_EX2_IR = 4'he, T_UPD_IR = 4'hf;
  localparam [1:0] E_IDLE = 2'h0, E_RUN = 2'h1, E_DONE = 2'h2;
  function [3:0] tap_next;
    input [3:0] s;
    input       m;
    begin
      case (s)
        T_RESET:  tap_next = m ? T_RESET  : T_IDLE;
        T_IDLE:   tap_next = m ? T_SEL_DR : T_IDLE;
        T_SEL_DR: tap_next = m ? T_SEL_IR : T_CAP_DR;
        T_CAP_DR: tap_next = m ? T_EX1_DR : T_SH_DR;
        T_SH_DR:  tap_next = m ? T_EX1_DR : T_SH_DR;
        T_EX1_DR: tap_next = m ? T_UPD_DR : T_PAU_DR;
        T_PAU_DR: tap_next = m ? T_EX2_DR : T_PAU_DR;
        T_EX2_DR: tap_next = m ? T_UPD_DR : T_SH_DR;
        T_UPD_DR: tap_next = m ? T_SEL_DR : T_IDLE;
        T_SEL_IR: tap_next = m ? T_RESET  : T_CAP_IR;
        T_CAP_IR: tap_next = m ? T_EX1_IR : T_SH_IR;
        T_SH_IR:  tap_next = m ? T_EX1_IR : T_SH_IR;
        T_EX1_IR: tap_next = m ? T_UPD_IR : T_PAU_IR;
        T_PAU_IR: tap_next = m ? T_EX2_IR : T_PAU_IR;
        T_EX2_IR: tap_next = m ? T_UPD_IR : T_SH_IR;
        T_UPD_IR: tap_next = m ? T_SEL_DR : T_IDLE;
        default:  tap_next = T_RESET;
      endcase
    end
  endfunction
  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  reg       rst_s1_q;
  reg [1:0] strap_s_q;
  reg [2:0] tck_s_q;
  reg [1:0] tms_s_q;
  reg [1:0] tdi_s_q;
  reg [1:0] trst_s_q;
  // strap sync left unreset: its level must be settled at the boot latch edge
  always @(posedge pclk)
    strap_s_q <= {strap_s_q[0], external_boot_strap};
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_s1_q     <= 1'b0;
      core_reset_n <= 1'b0;
      tck_s_q      <= 3'b000;
      tms_s_q      <= 2'b11;
      tdi_s_q      <= 2'b00;
      trst_s_q     <= 2'b00;
    end
    else
    begin
      rst_s1_q     <= 1'b1;
      core_reset_n <= rst_s1_q;
      tck_s_q      <= {tck_s_q[1:0], tck};
      tms_s_q      <= {tms_s_q[0], tms};
      tdi_s_q      <= {tdi_s_q[0], tdi};
      trst_s_q     <= {trst_s_q[0], trst_n};
    end
  end
  wire tck_rise = tck_s_q[1] & ~tck_s_q[2];
  wire tck_fall = ~tck_s_q[1] & tck_s_q[2];
  // ----------------------------------------------------------------
  // security decode and boot mode latch
  // ----------------------------------------------------------------
  reg        erased_q;
  reg        boot_done_q;
  reg        secured_q;
  reg        strap_q;
  reg        backdoor_q;
  wire [15:0] sec_word = erased_q ? `FSL_ERASED_WORD : nv_security_word;
  wire        sec_now  = (sec_word[1:0] == `FSL_SEC_LOCK_CODE);
  wire        key_en   = (sec_word[15:14] == `FSL_KEY_EN_CODE);
  wire        apb_wr;
  wire        unlock_wr;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_done_q        <= 1'b0;
      secured_q          <= 1'b1;
      strap_q            <= 1'b0;
      backdoor_q         <= 1'b0;
      boot_mode          <= `FSL_MODE_SECURE;
      boot_vector        <= `FSL_BOOT_VECTOR;
      ext_pspace_block   <= 1'b1;
      debug_read_disable <= 1'b1;
    end
    else if (!boot_done_q && rst_s1_q)
    begin
      boot_done_q        <= 1'b1;
      secured_q          <= sec_now;
      strap_q            <= strap_s_q[1];
      debug_read_disable <= sec_now;
      ext_pspace_block   <= sec_now;
      boot_mode          <= sec_now ? `FSL_MODE_SECURE :
                            (strap_s_q[1] ? `FSL_MODE_EXTERNAL : `FSL_MODE_INTERNAL);
      boot_vector        <= (sec_now || !strap_s_q[1]) ? `FSL_BOOT_VECTOR :
                            `FSL_EXT_VECTOR;
    end
    else if (unlock_wr && secured_q && key_en)
    begin
      backdoor_q         <= 1'b1;
      ext_pspace_block   <= 1'b0;
      debug_read_disable <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // jtag tap, sampled on synchronised tck edges
  // ----------------------------------------------------------------
  reg [3:0]  tap_q;
  reg [3:0]  ir_q;
  reg [3:0]  ir_sh_q;
  reg [31:0] dr_sh_q;
  reg [6:0]  jtag_div_q;
  reg        div_loaded_q;
  reg [31:0] dr_cap;
  always @*
  begin
    case (ir_q)
      `FSL_IR_IDCODE:  dr_cap = `FSL_IDCODE_VALUE;
      `FSL_IR_LOCKOUT: dr_cap = {25'h0, jtag_div_q};
      default:         dr_cap = 32'h0;
    endcase
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tap_q        <= T_RESET;
      ir_q         <= `FSL_IR_IDCODE;
      ir_sh_q      <= 4'h0;
      dr_sh_q      <= 32'h0;
      jtag_div_q   <= 7'h00;
      div_loaded_q <= 1'b0;
      tdo          <= 1'b0;
      tdo_oe       <= 1'b0;
    end
    else if (!trst_s_q[1])
    begin
      tap_q        <= T_RESET;
      ir_q         <= `FSL_IR_IDCODE;
      div_loaded_q <= 1'b0;
      tdo_oe       <= 1'b0;
    end
    else if (tck_rise)
    begin
      tap_q <= tap_next(tap_q, tms_s_q[1]);
      case (tap_q)
        T_RESET:
        begin
          ir_q         <= `FSL_IR_IDCODE;
          div_loaded_q <= 1'b0;
        end
        T_CAP_IR: ir_sh_q <= `FSL_IR_CAPTURE;
        T_SH_IR:  ir_sh_q <= {tdi_s_q[1], ir_sh_q[3:1]};
        T_UPD_IR: ir_q    <= ir_sh_q;
        T_CAP_DR: dr_sh_q <= dr_cap;
        T_SH_DR:
          case (ir_q)
            `FSL_IR_IDCODE:  dr_sh_q <= {tdi_s_q[1], dr_sh_q[31:1]};
            `FSL_IR_LOCKOUT: dr_sh_q <= {25'h0, tdi_s_q[1], dr_sh_q[6:1]};
            default:         dr_sh_q <= {31'h0, tdi_s_q[1]};
          endcase
        T_UPD_DR:
          if (ir_q == `FSL_IR_LOCKOUT)
          begin
            jtag_div_q   <= dr_sh_q[6:0];
            div_loaded_q <= 1'b1;
          end
        default: ;
      endcase
    end
    else if (tck_fall)
    begin
      tdo    <= (tap_q == T_SH_IR) ? ir_sh_q[0] : dr_sh_q[0];
      tdo_oe <= (tap_q == T_SH_IR) || (tap_q == T_SH_DR);
    end
  end
  // ----------------------------------------------------------------
  // timed-event divider
  // ----------------------------------------------------------------
  reg  [6:0] clkdiv_q;
  reg        half_q;
  reg  [2:0] pre_q;
  reg  [5:0] ratio_q;
  reg  [1:0] erase_q;
  reg  [15:0] ticks_q;
  wire       in_erase = (erase_q == E_RUN);
  wire [6:0] div_sel  = in_erase ? jtag_div_q : clkdiv_q;
  wire       pre_en   = half_q & (~div_sel[`FSL_DIV_PRESCALE] | (pre_q == 3'h7));
  wire       tick     = pre_en & (ratio_q == div_sel[5:0]);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      half_q           <= 1'b0;
      pre_q            <= 3'h0;
      ratio_q          <= 6'h00;
      flash_event_tick <= 1'b0;
    end
    else
    begin
      half_q           <= ~half_q;
      flash_event_tick <= tick;
      if (half_q)
        pre_q <= pre_q + 3'h1;
      if (tick)
        ratio_q <= 6'h00;
      else if (pre_en)
        ratio_q <= ratio_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // lockout recovery erase sequence
  // ----------------------------------------------------------------
  wire in_rti = (tap_q == T_IDLE) && (ir_q == `FSL_IR_LOCKOUT);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      erase_q        <= E_IDLE;
      ticks_q        <= 16'h0000;
      erased_q       <= 1'b0;
      mass_erase_req <= 1'b0;
    end
    else
    begin
      case (erase_q)
        E_IDLE:
        begin
          ticks_q <= 16'h0000;
          if (in_rti && div_loaded_q)
          begin
            erase_q        <= E_RUN;
            mass_erase_req <= 1'b1;
          end
        end
        E_RUN:
        begin
          if (!in_rti)
          begin
            erase_q        <= E_IDLE;
            mass_erase_req <= 1'b0;
          end
          else if (tick && ticks_q == ERASE_TICKS - 16'h0001)
          begin
            erase_q        <= E_DONE;
            mass_erase_req <= 1'b0;
            erased_q       <= 1'b1;
          end
          else if (tick)
            ticks_q <= ticks_q + 16'h0001;
        end
        E_DONE: erase_q <= E_DONE;
        default: erase_q <= E_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb slave, no wait states
  // ----------------------------------------------------------------
  wire setup  = psel & ~penable;
  assign apb_wr    = psel & penable & pready & pwrite;
  assign unlock_wr = apb_wr && (paddr == `FSL_OFF_CONTROL) && pwdata[`FSL_CTL_UNLOCK];
  reg  [31:0] rd_mux;
  reg         hit;
  always @*
  begin
    rd_mux = 32'h0;
    hit    = 1'b1;
    case (paddr)
      `FSL_OFF_STATUS:
        rd_mux[`FSL_ST_ERASED:`FSL_ST_SECURED] = {erased_q, in_erase, strap_q, backdoor_q,
                                                  key_en, boot_mode, secured_q & ~backdoor_q};
      `FSL_OFF_CONTROL:  rd_mux = 32'h0;
      `FSL_OFF_CLKDIV:   rd_mux[6:0] = clkdiv_q;
      `FSL_OFF_RECOVERY: rd_mux[`FSL_RC_LOADED:0] = {div_loaded_q, jtag_div_q};
      default:           hit = 1'b0;
    endcase
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0;
      clkdiv_q <= `FSL_CLKDIV_RESET;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      if (setup && (!pwrite || !hit))                 // unmapped write also shows zero data
        prdata <= rd_mux;
      if (apb_wr && paddr == `FSL_OFF_CLKDIV)
        clkdiv_q <= pwdata[6:0];
    end
  end
endmodule // fsl_lockout
`default_nettype wire

// ---- test/fsl_lockout_props.sv ----
// checker: boot, reset, apb and erase properties of the lockout block
`default_nettype none
`include "fsl_map.vh"

module fsl_lockout_props #(
  parameter [15:0] ERASE_TICKS = 16'h0004
) (
  input wire logic        pclk,                // core clock
  input wire logic        presetn,             // async reset
  input wire logic        psel,                // apb select
  input wire logic        penable,             // apb access
  input wire logic [31:0] prdata,              // apb read data
  input wire logic        pready,              // apb ready
  input wire logic        pslverr,             // apb error
  input wire logic [15:0] nv_security_word,    // security bytes
  input wire logic        external_boot_strap, // strap pin
  input wire logic        trst_n,              // test reset
  input wire logic        core_reset_n,        // internal reset
  input wire logic [1:0]  boot_mode,           // functional mode
  input wire logic [23:0] boot_vector,         // first fetch
  input wire logic        ext_pspace_block,    // p-space block
  input wire logic        debug_read_disable,  // debug reads off
  input wire logic        mass_erase_req,      // erase active
  input wire logic        flash_event_tick     // event tick
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // helpers
  // ------
  logic        sec;
  logic        rel;
  logic        crst_q;
  logic [15:0] tick_cnt_q;
  assign sec = (nv_security_word[1:0] == `FSL_SEC_LOCK_CODE);
  assign rel = core_reset_n & ~crst_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      crst_q <= 1'b0;
    else
      crst_q <= core_reset_n;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tick_cnt_q <= 16'h0000;
    else if (!mass_erase_req)
      tick_cnt_q <= 16'h0000;
    else if (flash_event_tick)
      tick_cnt_q <= tick_cnt_q + 16'h0001;
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------
  // properties
  // ------
  reset_release_a: assert property ($rose(presetn) |->
    !core_reset_n ##1 !core_reset_n ##1 core_reset_n) else $error("reset release late");
  secure_boot_a: assert property (rel && sec |->
    boot_mode == `FSL_MODE_SECURE && boot_vector == `FSL_BOOT_VECTOR)
    else $error("secured part not in secure boot");
  strap_ignored_a: assert property (rel && sec && external_boot_strap |->
    boot_mode != `FSL_MODE_EXTERNAL) else $error("strap obeyed while secured");
  open_boot_a: assert property (rel && !sec |->
    boot_mode == (external_boot_strap ? `FSL_MODE_EXTERNAL : `FSL_MODE_INTERNAL))
    else $error("wrong open boot mode");
  debug_block_a: assert property (rel |-> debug_read_disable == sec)
    else $error("debug disable wrong at boot");
  pspace_block_a: assert property (rel |-> ext_pspace_block == sec)
    else $error("p-space block wrong at boot");
  erase_count_a: assert property ($fell(mass_erase_req) && trst_n |->
    tick_cnt_q + 16'h0001 >= ERASE_TICKS && tick_cnt_q <= ERASE_TICKS)
    else $error("erase tick count wrong");
  apb_ready_a: assert property (psel && !penable |=> pready && penable)
    else $error("no ready in access cycle");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response carries data");
  cover property (rel && sec);
  cover property ($rose(mass_erase_req));
  cover property (pslverr);
endmodule // fsl_lockout_props

bind fsl_lockout fsl_lockout_props #(.ERASE_TICKS(ERASE_TICKS)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .nv_security_word(nv_security_word),
  .external_boot_strap(external_boot_strap), .trst_n(trst_n), .core_reset_n(core_reset_n),
  .boot_mode(boot_mode), .boot_vector(boot_vector), .ext_pspace_block(ext_pspace_block),
  .debug_read_disable(debug_read_disable), .mass_erase_req(mass_erase_req),
  .flash_event_tick(flash_event_tick));
`default_nettype wire

// ---- test/fsl_jtag_host.sv ----
// jtag host model: drives the tap pins of the lockout block
`default_nettype none

module fsl_jtag_host #(
  parameter int HALF = 8
) (
  input  wire logic pclk,   // core clock, paces tck
  input  wire logic tdo,    // tap data out
  output var  logic tck,    // test clock, still between scans
  output var  logic tms,    // mode select
  output var  logic tdi,    // data in
  output var  logic trst_n  // test reset, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end
  // one tck period, tdo taken just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (HALF) @(posedge pclk);
    q = tdo;
    tck <= 1'b1;
    repeat (HALF) @(posedge pclk);
    tck <= 1'b0;
  endtask
  task automatic tap_reset();
    logic q;
    trst_n <= 1'b0;
    repeat (HALF) @(posedge pclk);
    trst_n <= 1'b1;
    repeat (HALF) @(posedge pclk);
    step(1'b0, 1'b0, q);
  endtask
  // from run-test/idle through one ir or dr scan back to run-test/idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule // fsl_jtag_host
`default_nettype wire

// ---- test/test_flash_security_lockout.sv ----
// testbench for the flash security lockout block
`default_nettype none
`include "fsl_map.vh"

module test_flash_security_lockout;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] nv_word = 16'hfffe;
  logic        strap = 1'b1;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        trst_n;
  logic        tdo;
  logic        tdo_en;
  logic [1:0]  boot_mode;
  logic [23:0] boot_vector;
  logic        pspace_block;
  logic        debug_off;
  logic        erase_req;
  logic        tick;
  int          err_total = 0;
  int          num_checks = 0;

  always #5 pclk = ~pclk;

  fsl_lockout #(.ERASE_TICKS(16'h0004)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nv_security_word(nv_word), .external_boot_strap(strap), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_en), .core_reset_n(),
    .boot_mode(boot_mode), .boot_vector(boot_vector), .ext_pspace_block(pspace_block),
    .debug_read_disable(debug_off), .mass_erase_req(erase_req), .flash_event_tick(tick));
  fsl_jtag_host u_host (.pclk(pclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n));

  // ------
  // shared tasks
  // ------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset(input logic [15:0] nv, input logic s);
    @(posedge pclk);
    presetn <= 1'b0;
    nv_word <= nv;
    strap <= s;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  task automatic check_boot(input logic [1:0] m, input logic [23:0] v, input logic blk);
    @(negedge pclk);
    check("boot_mode", {30'h0, m}, {30'h0, boot_mode});
    check("boot_vector", {8'h0, v}, {8'h0, boot_vector});
    check("pspace_block", {31'h0, blk}, {31'h0, pspace_block});
    check("debug_off", {31'h0, blk}, {31'h0, debug_off});
  endtask
  task automatic wait_tick(output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (tick !== 1'b1 && n < 3000);
  endtask
  // ------
  // scenarios
  // ------
  task automatic test_boot_modes();
    logic [31:0] rd;
    logic        err;
    do_reset(16'hfffe, 1'b1);
    check_boot(`FSL_MODE_SECURE, `FSL_BOOT_VECTOR, 1'b1);
    apb(1'b0, `FSL_OFF_STATUS, 32'h0, rd, err);
    check("status", 32'h0000_0025, rd);
    apb(1'b1, `FSL_OFF_CONTROL, 32'h1, rd, err);
    check_boot(`FSL_MODE_SECURE, `FSL_BOOT_VECTOR, 1'b1);
    apb(1'b0, 12'h010, 32'h0, rd, err);
    check("unmapped err", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    do_reset(16'hffff, 1'b1);
    check_boot(`FSL_MODE_EXTERNAL, `FSL_EXT_VECTOR, 1'b0);
    do_reset(16'hfffe, 1'b0);
    check_boot(`FSL_MODE_SECURE, `FSL_BOOT_VECTOR, 1'b1);
    do_reset(16'hffff, 1'b0);
    check_boot(`FSL_MODE_INTERNAL, `FSL_BOOT_VECTOR, 1'b0);
    do_reset(16'hbffe, 1'b0);
    apb(1'b1, `FSL_OFF_CONTROL, 32'h1, rd, err);
    check_boot(`FSL_MODE_SECURE, `FSL_BOOT_VECTOR, 1'b0);
    $display("test_boot_modes done");
  endtask
  task automatic test_tap();
    logic [31:0] rd;
    do_reset(16'hfffe, 1'b0);
    u_host.tap_reset();
    u_host.scan(1'b0, 32, 32'h0, rd);
    check("idcode", `FSL_IDCODE_VALUE, rd);
    u_host.scan(1'b1, 4, 32'h0000_000f, rd);
    check("ir capture", {28'h0, `FSL_IR_CAPTURE}, rd);
    repeat (4) @(posedge pclk);
    check("tdo_oe idle", 32'h0, {31'h0, tdo_en});
    $display("test_tap done");
  endtask
  task automatic test_recovery(input logic [6:0] div, input int period);
    logic [31:0] rd;
    logic        err;
    int          n;
    do_reset(16'hfffe, 1'b0);
    apb(1'b1, `FSL_OFF_CLKDIV, 32'h0000_0005, rd, err);
    apb(1'b0, `FSL_OFF_CLKDIV, 32'h0, rd, err);
    check("clkdiv", 32'h5, rd);
    wait_tick(n);
    wait_tick(n);
    check("own tick period", 32'd12, n);
    u_host.tap_reset();
    u_host.scan(1'b1, 4, {28'h0, `FSL_IR_LOCKOUT}, rd);
    u_host.scan(1'b0, 7, {25'h0, div}, rd);
    for (n = 0; erase_req !== 1'b1 && n < 40; n++)
      @(posedge pclk);
    check("erase start", 32'h1, {31'h0, erase_req});
    wait_tick(n);
    wait_tick(n);
    check("tick period", period, n);
    for (n = 0; erase_req === 1'b1 && n < 5000; n++)
      @(posedge pclk);
    apb(1'b0, `FSL_OFF_STATUS, 32'h0, rd, err);
    check("erased", 32'h80, rd & 32'hc0);
    apb(1'b0, `FSL_OFF_RECOVERY, 32'h0, rd, err);
    check("recovery", {24'h0, 1'b1, div}, rd);
    u_host.tap_reset();
    do_reset(16'hffff, 1'b1);
    check_boot(`FSL_MODE_EXTERNAL, `FSL_EXT_VECTOR, 1'b0);
    $display("test_recovery done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    test_boot_modes();
    test_tap();
    test_recovery(7'h60, 528);
    test_recovery(7'h68, 656);
    final_report();
  end
  initial
  begin
    repeat (40000) @(posedge pclk);
    err_total++;
    final_report();
  end
endmodule // test_flash_security_lockout
`default_nettype wire
